/* logic/iafbg_filt_if.sv */
// Interface between the register block and the input spike filter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface iafbg_filt_if;
    logic filt_en;
    logic sda_raw;
    logic scl_raw;
    logic sda_clean;
    logic scl_clean;

    modport ctrl (output filt_en, output sda_raw, output scl_raw, input sda_clean, input scl_clean);
    modport filt (input filt_en, input sda_raw, input scl_raw, output sda_clean, output scl_clean);
endinterface : iafbg_filt_if

/* logic/iafbg_pkg.sv */
// Package for the serial bus acknowledge, filter and baud block.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
package iafbg_pkg;

    // Register indices; the byte address is four times the index
    localparam int unsigned IDX_W = 24;
    localparam logic [23:0] IDX_CTRL = 24'hFFE242;
    localparam logic [23:0] IDX_BHI = 24'hFFE243;
    localparam logic [23:0] IDX_BLO = 24'hFFE244;
    localparam logic [23:0] IDX_TXD = 24'hFFE246;
    localparam logic [23:0] IDX_STAT = 24'hFFE247;

    // Control register bit positions
    localparam int unsigned CTRL_EN = 7;
    localparam int unsigned CTRL_DSEL = 5;
    localparam int unsigned CTRL_TSEL = 4;
    localparam int unsigned CTRL_NACK = 2;
    localparam int unsigned CTRL_FLUSH = 1;
    localparam int unsigned CTRL_FILT = 0;

    // Status register bit positions
    localparam int unsigned STAT_TXE = 0;
    localparam int unsigned STAT_NACK = 1;

    // Reset values
    localparam logic [7:0] BAUD_BYTE_RESET = 8'hFF;
    localparam logic [15:0] BAUD_CNT_RESET = 16'hFFFF;
    localparam logic [15:0] BAUD_TERM = 16'h0001;
    localparam logic [7:0] TXD_RESET = 8'h00;
    localparam logic LINE_IDLE = 1'b1;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        IAFBG_CH_IDLE = 2'h1,
        IAFBG_CH_RESP = 2'h2
    } iafbg_ch_t;

endpackage : iafbg_pkg

/* logic/iafbg_spike_filter.sv */
// Spike filter for the serial data and clock inputs.
// Assumes raw inputs are already synchronous to clk.
`timescale 1ns/1ps
module iafbg_spike_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Filter link
    iafbg_filt_if.filt fif
);

    logic [1:0] raw;
    logic [1:0] stage0_ff;
    logic [1:0] stage1_ff;
    logic [1:0] out_ff;

    assign raw = {fif.scl_raw, fif.sda_raw};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage0_ff <= {2{iafbg_pkg::LINE_IDLE}};
            stage1_ff <= {2{iafbg_pkg::LINE_IDLE}};
        end
        else
        begin
            stage0_ff <= raw;
            stage1_ff <= stage0_ff;
        end
    end

    // Two agreeing samples are needed, so a one-cycle pulse never passes while filt_en is set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out_ff <= {2{iafbg_pkg::LINE_IDLE}};
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (!fif.filt_en)
                begin
                    out_ff[i] <= raw[i];
                end
                else if (stage0_ff[i] == stage1_ff[i])
                begin
                    out_ff[i] <= stage1_ff[i];
                end
            end
        end
    end

    assign fif.sda_clean = out_ff[0];
    assign fif.scl_clean = out_ff[1];

endmodule : iafbg_spike_filter

/* logic/iafbg_top.sv */
// Acknowledge control, input filters and baud generator of the bus controller.
// Assumes the transaction engine reports nack_sent and tx_taken as pulses.
// Notes on behaviour
// - Send-nack makes next received byte not-acknowledged
// - Send-nack self-clears after nack or disable
// - Software cannot clear a set send-nack
// - Flush empties transmit data, sets empty flag
// - Flush bit always reads as zero
// - Filter enable filters both serial inputs
// - Filters suppress pulses under two clocks
// - Filters delay inputs three clock cycles
// - Reload value joins high and low bytes
// - Reload value used in slave and master
// - Bit rate is clock over four times reload
// - Zero reload counts as 65536
// - High byte register read-write, resets all ones
// - Low byte register read-write, resets all ones
// - Diagnostic read of high byte shows counter
// - Diagnostic read of low byte shows counter
// - Enable bit switches controller, cancels requests
// - Disabled with timer select, counter interrupts
`timescale 1ns/1ps
module iafbg_top (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial bus inputs and their filtered copies
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_filt,
    output logic scl_filt,
    // Transaction engine side
    input wire logic nack_sent,
    input wire logic tx_taken,
    output logic controller_enable_bit,
    output logic send_nack,
    output logic [7:0] tx_data,
    output logic transmit_data_empty_flag,
    output logic quarter_bit_tick,
    output logic baud_timer_irq
);

    function automatic logic hit(input logic [31:0] addr, input logic [23:0] idx);
        hit = (addr == {6'h00, idx, 2'h0});
    endfunction : hit

    function automatic logic mapped(input logic [31:0] addr);
        mapped = hit(addr, iafbg_pkg::IDX_CTRL) || hit(addr, iafbg_pkg::IDX_BHI)
            || hit(addr, iafbg_pkg::IDX_BLO) || hit(addr, iafbg_pkg::IDX_TXD)
            || hit(addr, iafbg_pkg::IDX_STAT);
    endfunction : mapped

    // Bus channel state
    iafbg_pkg::iafbg_ch_t wr_state_ff;
    iafbg_pkg::iafbg_ch_t rd_state_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Block state
    logic en_ff;
    logic dsel_ff;
    logic tsel_ff;
    logic filt_en_ff;
    logic nack_ff;
    logic [7:0] bhi_ff;
    logic [7:0] blo_ff;
    logic [15:0] cnt_ff;
    logic [7:0] txd_ff;
    logic txe_ff;
    logic tick_ff;
    logic irq_ff;

    // Decoded strobes
    logic wr_do;
    logic ctrl_wr;
    logic bhi_wr;
    logic blo_wr;
    logic txd_wr;
    logic flush;
    logic en_now;
    logic [15:0] reload;
    logic run;
    logic term;
    logic [7:0] rd_byte;

    iafbg_filt_if fif ();

    assign fif.filt_en = filt_en_ff;
    assign fif.sda_raw = sda_in;
    assign fif.scl_raw = scl_in;

    iafbg_spike_filter u_filter (
        .clk (clk),
        .nrst (nrst),
        .fif (fif)
    );

    // Write channel: address and data taken in either order
    assign wr_do = (wr_state_ff == iafbg_pkg::IAFBG_CH_IDLE) && aw_got_ff && w_got_ff;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_state_ff <= iafbg_pkg::IAFBG_CH_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= iafbg_pkg::RESP_OKAY;
        end
        else
        begin
            unique case (wr_state_ff)
                iafbg_pkg::IAFBG_CH_IDLE:
                begin
                    if (s_axi_awvalid && awready_ff)
                    begin
                        aw_got_ff <= 1'b1;
                        awaddr_ff <= s_axi_awaddr;
                        awready_ff <= 1'b0;
                    end
                    if (s_axi_wvalid && wready_ff)
                    begin
                        w_got_ff <= 1'b1;
                        wdata_ff <= s_axi_wdata;
                        wstrb_ff <= s_axi_wstrb;
                        wready_ff <= 1'b0;
                    end
                    if (wr_do)
                    begin
                        wr_state_ff <= iafbg_pkg::IAFBG_CH_RESP;
                        bvalid_ff <= 1'b1;
                        bresp_ff <= mapped(awaddr_ff) ? iafbg_pkg::RESP_OKAY : iafbg_pkg::RESP_SLVERR;
                    end
                end
                iafbg_pkg::IAFBG_CH_RESP:
                begin
                    if (s_axi_bready)
                    begin
                        wr_state_ff <= iafbg_pkg::IAFBG_CH_IDLE;
                        bvalid_ff <= 1'b0;
                        aw_got_ff <= 1'b0;
                        w_got_ff <= 1'b0;
                        awready_ff <= 1'b1;
                        wready_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign ctrl_wr = wr_do && wstrb_ff[0] && hit(awaddr_ff, iafbg_pkg::IDX_CTRL);
    assign bhi_wr = wr_do && wstrb_ff[0] && hit(awaddr_ff, iafbg_pkg::IDX_BHI);
    assign blo_wr = wr_do && wstrb_ff[0] && hit(awaddr_ff, iafbg_pkg::IDX_BLO);
    assign txd_wr = wr_do && wstrb_ff[0] && hit(awaddr_ff, iafbg_pkg::IDX_TXD);
    assign flush = ctrl_wr && wdata_ff[iafbg_pkg::CTRL_FLUSH];
    assign en_now = ctrl_wr ? wdata_ff[iafbg_pkg::CTRL_EN] : en_ff;

    // Control bits
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            en_ff <= 1'b0;
            dsel_ff <= 1'b0;
            tsel_ff <= 1'b0;
            filt_en_ff <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            en_ff <= wdata_ff[iafbg_pkg::CTRL_EN];
            dsel_ff <= wdata_ff[iafbg_pkg::CTRL_DSEL];
            tsel_ff <= wdata_ff[iafbg_pkg::CTRL_TSEL];
            filt_en_ff <= wdata_ff[iafbg_pkg::CTRL_FILT];
        end
    end

    // Software set wins over a nack completing in the same cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            nack_ff <= 1'b0;
        end
        else if (ctrl_wr && wdata_ff[iafbg_pkg::CTRL_NACK] && en_now)
        begin
            nack_ff <= 1'b1;
        end
        else if (nack_sent || !en_now)
        begin
            nack_ff <= 1'b0;
        end
    end

    // Transmit data register and its empty flag
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            txd_ff <= iafbg_pkg::TXD_RESET;
        end
        else if (flush)
        begin
            txd_ff <= iafbg_pkg::TXD_RESET;
        end
        else if (txd_wr)
        begin
            txd_ff <= wdata_ff[7:0];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            txe_ff <= 1'b1;
        end
        else if (flush || tx_taken)
        begin
            txe_ff <= 1'b1;
        end
        else if (txd_wr)
        begin
            txe_ff <= 1'b0;
        end
    end

    // Baud reload bytes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bhi_ff <= iafbg_pkg::BAUD_BYTE_RESET;
            blo_ff <= iafbg_pkg::BAUD_BYTE_RESET;
        end
        else
        begin
            if (bhi_wr)
            begin
                bhi_ff <= wdata_ff[7:0];
            end
            if (blo_wr)
            begin
                blo_ff <= wdata_ff[7:0];
            end
        end
    end

    // One reload feeds master and slave timing alike
    assign reload = {bhi_ff, blo_ff};
    assign run = en_ff || tsel_ff;
    assign term = (cnt_ff == iafbg_pkg::BAUD_TERM);

    // Zero reload wraps through FFFF down to one, giving 65536 counts
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_ff <= iafbg_pkg::BAUD_CNT_RESET;
        end
        else if (!run || term)
        begin
            cnt_ff <= reload;
        end
        else
        begin
            cnt_ff <= cnt_ff - 16'h0001;
        end
    end

    // Tick marks a quarter bit; the engine builds bit times from four of them
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tick_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= en_ff && term;
            irq_ff <= !en_ff && tsel_ff && term;
        end
    end

    // Read data selection
    always_comb
    begin
        rd_byte = 8'h00;
        if (hit(s_axi_araddr, iafbg_pkg::IDX_CTRL))
        begin
            rd_byte[iafbg_pkg::CTRL_EN] = en_ff;
            rd_byte[iafbg_pkg::CTRL_DSEL] = dsel_ff;
            rd_byte[iafbg_pkg::CTRL_TSEL] = tsel_ff;
            rd_byte[iafbg_pkg::CTRL_NACK] = nack_ff;
            rd_byte[iafbg_pkg::CTRL_FLUSH] = 1'b0;
            rd_byte[iafbg_pkg::CTRL_FILT] = filt_en_ff;
        end
        else if (hit(s_axi_araddr, iafbg_pkg::IDX_BHI))
        begin
            rd_byte = dsel_ff ? cnt_ff[15:8] : bhi_ff;
        end
        else if (hit(s_axi_araddr, iafbg_pkg::IDX_BLO))
        begin
            rd_byte = dsel_ff ? cnt_ff[7:0] : blo_ff;
        end
        else if (hit(s_axi_araddr, iafbg_pkg::IDX_TXD))
        begin
            rd_byte = txd_ff;
        end
        else if (hit(s_axi_araddr, iafbg_pkg::IDX_STAT))
        begin
            rd_byte[iafbg_pkg::STAT_TXE] = txe_ff;
            rd_byte[iafbg_pkg::STAT_NACK] = nack_ff;
        end
    end

    // Read channel: one read at a time, answer one cycle after the address
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_state_ff <= iafbg_pkg::IAFBG_CH_IDLE;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= iafbg_pkg::RESP_OKAY;
        end
        else
        begin
            unique case (rd_state_ff)
                iafbg_pkg::IAFBG_CH_IDLE:
                begin
                    if (s_axi_arvalid)
                    begin
                        rd_state_ff <= iafbg_pkg::IAFBG_CH_RESP;
                        arready_ff <= 1'b0;
                        rvalid_ff <= 1'b1;
                        rdata_ff <= {24'h00_0000, rd_byte};
                        rresp_ff <= mapped(s_axi_araddr) ? iafbg_pkg::RESP_OKAY : iafbg_pkg::RESP_SLVERR;
                    end
                end
                iafbg_pkg::IAFBG_CH_RESP:
                begin
                    if (s_axi_rready)
                    begin
                        rd_state_ff <= iafbg_pkg::IAFBG_CH_IDLE;
                        arready_ff <= 1'b1;
                        rvalid_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign sda_filt = fif.sda_clean;
    assign scl_filt = fif.scl_clean;
    assign controller_enable_bit = en_ff;
    assign send_nack = nack_ff;
    assign tx_data = txd_ff;
    assign transmit_data_empty_flag = txe_ff;
    assign quarter_bit_tick = tick_ff;
    assign baud_timer_irq = irq_ff;

endmodule : iafbg_top

/* testbench/iafbg_checker.sv */
// Port checks for the acknowledge, filter and baud block.
// Assumes it is bound to iafbg_top on a single clock.
`timescale 1ns/1ps
module iafbg_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial data line
    input wire logic sda_in,
    input wire logic sda_filt,
    // Engine side
    input wire logic nack_sent,
    input wire logic tx_taken,
    input wire logic controller_enable_bit,
    input wire logic send_nack,
    input wire logic transmit_data_empty_flag,
    input wire logic quarter_bit_tick,
    input wire logic baud_timer_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    AST_WR_ANSWER: assert property (s_wr_take |=> s_wr_answer)
        else $error("write answer not two cycles after take");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accepted");
    AST_NACK_HOLD: assert property (send_nack && !nack_sent |=> send_nack || !controller_enable_bit)
        else $error("send nack cleared without cause");
    AST_NACK_OFF: assert property ($fell(controller_enable_bit) |-> ##[0:1] !send_nack)
        else $error("send nack kept after disable");
    AST_EMPTY_SET: assert property (tx_taken |=> transmit_data_empty_flag)
        else $error("empty flag not set after byte taken");
    AST_SDA_HIGH: assert property (sda_in [*4] |=> sda_filt)
        else $error("filtered data missed a steady high");
    AST_SDA_LOW: assert property (!sda_in [*4] |=> !sda_filt)
        else $error("filtered data missed a steady low");
    AST_TICK_IRQ: assert property (!(quarter_bit_tick && baud_timer_irq))
        else $error("tick and timer pulse together");
endmodule : iafbg_checker

bind iafbg_top iafbg_checker u_chk (
    .clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sda_in(sda_in), .sda_filt(sda_filt),
    .nack_sent(nack_sent), .tx_taken(tx_taken), .controller_enable_bit(controller_enable_bit),
    .send_nack(send_nack), .transmit_data_empty_flag(transmit_data_empty_flag),
    .quarter_bit_tick(quarter_bit_tick), .baud_timer_irq(baud_timer_irq)
);

/* testbench/iafbg_far_model.sv */
// Far side of the serial lines plus the transaction engine events.
// Assumes pull-ups hold both lines high when nobody drives them.
`timescale 1ns/1ps
module iafbg_far_model (
    // Clock
    input wire logic clk,
    // Serial lines at the pins
    output logic sda,
    output logic scl,
    // Engine events
    output logic nack_sent,
    output logic tx_taken
);
    initial
    begin
        sda = 1'b1;
        scl = 1'b1;
        nack_sent = 1'b0;
        tx_taken = 1'b0;
    end

    // Edges only on command; the chosen line holds lvl for n cycles, then both lines go high
    task automatic drive_line(input bit on_scl, input logic lvl, input int n);
        @(posedge clk);
        if (on_scl)
            scl <= lvl;
        else
            sda <= lvl;
        repeat (n) @(posedge clk);
        scl <= 1'b1;
        sda <= 1'b1;
    endtask : drive_line

    // One-cycle pulse: byte taken when which is 1, nack finished otherwise
    task automatic engine_event(input bit which);
        @(posedge clk);
        if (which)
            tx_taken <= 1'b1;
        else
            nack_sent <= 1'b1;
        @(posedge clk);
        tx_taken <= 1'b0;
        nack_sent <= 1'b0;
    endtask : engine_event
endmodule : iafbg_far_model

/* testbench/iafbg_tb_top.sv */
// Register-level bench for the acknowledge, filter and baud block.
// Assumes the far model drives the serial lines and engine events.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("MISMATCH %s exp %0h got %0h", nm, (exp), (got)); \
        end \
    end
module iafbg_tb_top;
    localparam logic [31:0] A_CTRL = {6'h00, iafbg_pkg::IDX_CTRL, 2'h0};
    localparam logic [31:0] A_BHI = {6'h00, iafbg_pkg::IDX_BHI, 2'h0};
    localparam logic [31:0] A_BLO = {6'h00, iafbg_pkg::IDX_BLO, 2'h0};
    localparam logic [31:0] A_TXD = {6'h00, iafbg_pkg::IDX_TXD, 2'h0};
    localparam logic [31:0] A_STAT = {6'h00, iafbg_pkg::IDX_STAT, 2'h0};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [31:0] awaddr = 32'h00000000;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] araddr = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sda, scl, nack_sent, tx_taken;
    logic sda_filt, scl_filt, en, send_nack, empty, tick, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d, d2;
    logic [7:0] tx_data;
    int n;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    iafbg_top dut (
        .clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sda_in(sda), .scl_in(scl), .sda_filt(sda_filt),
        .scl_filt(scl_filt), .nack_sent(nack_sent), .tx_taken(tx_taken), .controller_enable_bit(en),
        .send_nack(send_nack), .tx_data(tx_data), .transmit_data_empty_flag(empty),
        .quarter_bit_tick(tick), .baud_timer_irq(irq)
    );

    iafbg_far_model u_far (.clk(clk), .sda(sda), .scl(scl), .nack_sent(nack_sent), .tx_taken(tx_taken));

    task automatic complete_run();
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // Address and data are released separately, each when taken
    task automatic axi_write(input logic [31:0] a, input logic [7:0] v);
        bit aw_p = 1'b1;
        bit w_p = 1'b1;
        bit aw_go;
        bit w_go;
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_p || w_p)
        begin
            @(negedge clk);
            aw_go = aw_p && awready;
            w_go = w_p && wready;
            @(posedge clk);
            if (aw_go)
                awvalid <= 1'b0;
            if (w_go)
                wvalid <= 1'b0;
            aw_p = aw_p && !aw_go;
            w_p = w_p && !w_go;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge clk);
        bready <= 1'b0;
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] dat, output logic [1:0] rsp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        dat = rdata;
        rsp = rresp;
        @(posedge clk);
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_read

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [7:0] v);
        axi_read(a, d, r);
        `CHK(nm, {24'h000000, v}, d);
        `CHK({nm, "_resp"}, iafbg_pkg::RESP_OKAY, r);
    endtask : rd_chk

    // Cycles between two pulses of the tick or the timer output
    task automatic gap(input bit use_irq, output int cnt);
        cnt = 0;
        do @(negedge clk); while ((use_irq ? irq : tick) !== 1'b1);
        do
        begin
            @(negedge clk);
            cnt++;
        end
        while ((use_irq ? irq : tick) !== 1'b1);
        @(posedge clk);
    endtask : gap

    // Edges from the first sample of a falling line to its filtered copy
    task automatic line_delay(input bit on_scl, output int cnt);
        cnt = 0;
        fork
            u_far.drive_line(on_scl, 1'b0, 8);
            begin
                repeat (2) @(posedge clk);
                do
                begin
                    @(negedge clk);
                    cnt++;
                end
                while ((on_scl ? scl_filt : sda_filt) !== 1'b0 && cnt < 8);
            end
        join
        repeat (6) @(posedge clk);
    endtask : line_delay

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk("bhi_reset", A_BHI, 8'hFF);
        rd_chk("blo_reset", A_BLO, 8'hFF);
        axi_write(A_BHI, 8'h01);
        axi_write(A_BLO, 8'h04);
        `CHK("wr_resp", iafbg_pkg::RESP_OKAY, r);
        rd_chk("bhi_rw", A_BHI, 8'h01);
        rd_chk("blo_rw", A_BLO, 8'h04);
        axi_read(32'h00000040, d, r);
        `CHK("unmapped_resp", iafbg_pkg::RESP_SLVERR, r);
        axi_write(32'h00000040, 8'h00);
        `CHK("unmapped_wr_resp", iafbg_pkg::RESP_SLVERR, r);
        axi_write(A_CTRL, 8'h80);
        `CHK("enable_on", 1'b1, en);
        gap(1'b0, n);
        `CHK("tick_period", 260, n);
        axi_write(A_CTRL, 8'h10);
        gap(1'b1, n);
        `CHK("timer_period", 260, n);
        axi_write(A_CTRL, 8'h00);
        axi_write(A_BHI, 8'h00);
        axi_write(A_BLO, 8'h00);
        axi_write(A_CTRL, 8'hA0);
        rd_chk("dsel_high", A_BHI, 8'hFF);
        axi_read(A_BLO, d, r);
        axi_read(A_BLO, d2, r);
        `CHK("dsel_low_live", 1'b1, d !== d2);
        axi_write(A_CTRL, 8'h84);
        `CHK("nack_set", 1'b1, send_nack);
        rd_chk("stat_nack", A_STAT, 8'h03);
        axi_write(A_CTRL, 8'h80);
        `CHK("nack_sticky", 1'b1, send_nack);
        u_far.engine_event(1'b0);
        @(negedge clk);
        `CHK("nack_done", 1'b0, send_nack);
        @(posedge clk);
        axi_write(A_CTRL, 8'h84);
        axi_write(A_CTRL, 8'h00);
        `CHK("nack_disable", 1'b0, send_nack);
        `CHK("enable_off", 1'b0, en);
        axi_write(A_CTRL, 8'h80);
        axi_write(A_TXD, 8'hA5);
        `CHK("txd_load", 9'h0A5, {empty, tx_data});
        rd_chk("txd_read", A_TXD, 8'hA5);
        axi_write(A_CTRL, 8'h82);
        `CHK("txd_flush", 9'h100, {empty, tx_data});
        rd_chk("flush_reads_zero", A_CTRL, 8'h80);
        axi_write(A_TXD, 8'h5A);
        u_far.engine_event(1'b1);
        @(negedge clk);
        `CHK("taken_empty", 1'b1, empty);
        @(posedge clk);
        for (int f = 0; f < 2; f++)
        begin
            axi_write(A_CTRL, 8'(f));
            repeat (4) @(posedge clk);
            line_delay(1'b0, n);
            `CHK("sda_delay", (f == 1) ? 3 : 1, n);
        end
        line_delay(1'b1, n);
        `CHK("scl_delay", 3, n);
        n = 0;
        fork
            u_far.drive_line(1'b0, 1'b0, 1);
            repeat (8)
            begin
                @(negedge clk);
                n += (sda_filt !== 1'b1);
            end
        join
        `CHK("spike_removed", 0, n);
        complete_run();
    end
endmodule : iafbg_tb_top
